// ### design/pwr_wake_reset_ctrl.sv
// Reset, power state and wake control with a Wishbone register file.
// Assumes a classic Wishbone master, synchronous receive byte stream,
// and D3cold handled by power-on reset on rst_i.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module pwr_wake_reset_ctrl import pwr_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // System side
  input  wire logic        eeprom_wake_en_i,
  input  wire logic [1:0]  bus_state_i,
  input  wire logic        bus_clk_slow_i,
  input  wire logic [47:0] station_addr_i,
  // Receive path
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_sof_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_addr_ok_i,
  input  wire logic        rx_fcs_ok_i,
  // Control outputs
  output logic             chip_reset_o,
  output logic             xcvr_reset_o,
  output logic [14:0]      xcvr_ctrl_o,
  output logic [1:0]       pwr_state_o,
  output logic             net_en_o,
  output logic             func_en_o,
  output logic             cfg_en_o,
  output logic             pme_n_o,
  output logic             irq_o
);
  initial begin
    if (ADDR_W < 8) $error("pwr_wake_reset_ctrl: ADDR_W too small for map");
  end

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic              srst;
    logic              ld;
    logic              d3x;
    logic              xrst;
    logic [14:0]       xctl;
    logic              wake_en;
    logic              pme_sts;
    pwr_dstate_e       dst;
    logic [IRQ_N-1:0]  ists;
    logic [IRQ_N-1:0]  ien;
    logic              chip_rst;
    logic              net_en;
    logic              func_en;
    logic              cfg_en;
    logic              det_en;
    logic              pme_n;
    logic              irq;
  } pwr_st_s;

  // Power-up defaults; ld forces the EEPROM wake bit in after release
  localparam pwr_st_s ST_RST = '{
    ack:      1'b0,
    rdat:     32'h0000_0000,
    srst:     1'b0,
    ld:       1'b1,
    d3x:      1'b0,
    xrst:     1'b0,
    xctl:     XCTL_RST,
    wake_en:  WAKE_RST,
    pme_sts:  1'b0,
    dst:      PWR_D0,
    ists:     '0,
    ien:      '0,
    chip_rst: 1'b0,
    net_en:   1'b1,
    func_en:  1'b1,
    cfg_en:   1'b1,
    det_en:   1'b1,
    pme_n:    1'b1,
    irq:      1'b0
  };

  pwr_st_s r_reg, r_next;
  logic    wake_hit;
  logic    rst_det;

  ////////////////////////////////////////////////////////////////////
  // Wake pattern detector, held idle outside D0 and D1
  assign rst_det = rst_i | r_reg.chip_rst;

  pwr_wake_detect #(
    .SYNC_MIN (SYNC_FF_MIN),
    .REPS     (ADDR_REPS)
  ) u_det (
    .clk_i          (clk_i),
    .rst_i          (rst_det),
    .ce_i           (ce_i),
    .en_i           (r_reg.det_en),
    .station_addr_i (station_addr_i),
    .rx_valid_i     (rx_valid_i),
    .rx_data_i      (rx_data_i),
    .rx_sof_i       (rx_sof_i),
    .rx_eof_i       (rx_eof_i),
    .rx_addr_ok_i   (rx_addr_ok_i),
    .rx_fcs_ok_i    (rx_fcs_ok_i),
    .hit_o          (wake_hit)
  );

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte enables widened to a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // Config space reachable in this device and bus state
  function automatic logic cfg_ok(input pwr_dstate_e d, input logic [1:0] b);
    logic ok;
    ok = 1'b0;
    unique case (d)
      PWR_D0:    ok = 1'b1;
      PWR_D1:    ok = 1'b1;
      PWR_D2:    ok = (b == PWR_B0) || (b == PWR_B1);
      PWR_D3HOT: ok = (b == PWR_B0) || (b == PWR_B1);
    endcase
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic [31:0] wd;
  logic        req;
  logic        is_cfg;
  logic        acc_ok;
  logic        wr;
  pwr_st_s     keep;

  always_comb begin
    r_next = r_reg;
    keep   = r_reg;
    wd     = wb_dat_i & sel_mask(wb_sel_i);
    req    = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    is_cfg = (wb_adr_i[7:0] >= PWR_STS_OFS);
    // Function registers only in D0, config as the power state allows
    acc_ok = is_cfg ? r_reg.cfg_en : r_reg.func_en;
    wr     = req & wb_we_i & acc_ok;

    r_next.ack      = req;
    r_next.chip_rst = 1'b0;

    // Transceiver reset: one cycle of strobe, then defaults
    if (r_reg.xrst) begin
      r_next.xrst       = 1'b0;
      r_next.xctl       = XCTL_RST;
    end

    // Wake enable strap taken one cycle after any chip reset
    if (r_reg.ld) begin
      r_next.ld      = 1'b0;
      r_next.wake_en = eeprom_wake_en_i;
    end

    // Read mux; blocked or unmapped addresses read zero
    r_next.rdat = '0;
    if (req && !wb_we_i && acc_ok) begin
      unique case (wb_adr_i[7:0])
        MAIN_CTRL_OFS: r_next.rdat[SOFT_RST_BIT] = r_reg.srst;
        XCVR_CTRL_OFS: r_next.rdat[15:0] = {r_reg.xrst, r_reg.xctl};
        WAKE_CFG_OFS:  r_next.rdat[WAKE_EN_BIT] = r_reg.wake_en;
        PWR_STS_OFS: begin
          r_next.rdat[PME_STS_BIT] = r_reg.pme_sts;
          r_next.rdat[DSTATE_LSB +: 2] = r_reg.dst;
          r_next.rdat[BSTATE_LSB +: 2] = bus_state_i;
        end
        IRQ_STS_OFS:   r_next.rdat[IRQ_N-1:0] = r_reg.ists;
        IRQ_EN_OFS:    r_next.rdat[IRQ_N-1:0] = r_reg.ien;
        default:       r_next.rdat = '0;
      endcase
    end

    // Register writes; clears happen before hardware sets below
    if (wr) begin
      unique case (wb_adr_i[7:0])
        MAIN_CTRL_OFS: begin
          if (wd[SOFT_RST_BIT]) r_next.srst = 1'b1;
        end
        XCVR_CTRL_OFS: begin
          if (wb_sel_i[0]) r_next.xctl[7:0] = wd[7:0];
          if (wb_sel_i[1]) r_next.xctl[14:8] = wd[14:8];
          if (wd[XCVR_RST_BIT]) r_next.xrst = 1'b1;
        end
        WAKE_CFG_OFS: begin
          if (wb_sel_i[2]) r_next.wake_en = wd[WAKE_EN_BIT];
        end
        PWR_STS_OFS: begin
          if (wd[PME_STS_BIT]) r_next.pme_sts = 1'b0;
          if (wb_sel_i[0]) begin
            r_next.dst = pwr_dstate_e'(wd[DSTATE_LSB +: 2]);
            // Leaving D3hot for D0 restarts from power-up state
            if (r_reg.dst == PWR_D3HOT && r_next.dst == PWR_D0) begin
              r_next.d3x = 1'b1;
            end
          end
        end
        IRQ_CLR_OFS:   r_next.ists = r_next.ists & ~wd[IRQ_N-1:0];
        IRQ_EN_OFS:    r_next.ien  = wd[IRQ_N-1:0];
        default:       r_next.ien  = r_next.ien;
      endcase
    end

    // Transceiver reset done; set after the clear so the event wins
    if (r_reg.xrst) begin
      r_next.ists[EV_XRST] = 1'b1;
    end

    // Wake frame: the set wins over a clear in the same cycle
    if (wake_hit) begin
      r_next.ists[EV_WAKE] = 1'b1;
      if (r_reg.wake_en) begin
        r_next.pme_sts = 1'b1;
      end
    end

    // Whole-chip restart from software or D3hot exit; the event
    // status survives so a wake seen before the restart is kept
    if (r_reg.srst || r_reg.d3x) begin
      keep            = r_next;
      r_next          = ST_RST;
      r_next.pme_sts  = keep.pme_sts;
      r_next.ists     = keep.ists;
      r_next.ists[EV_SRST] = 1'b1;
      r_next.ack      = keep.ack;
      r_next.rdat     = keep.rdat;
      r_next.chip_rst = 1'b1;
      r_next.xrst     = 1'b0;
    end

    // Derived controls, registered so every output is a flop
    r_next.func_en = (r_next.dst == PWR_D0);
    r_next.net_en  = (r_next.dst == PWR_D0) & ~bus_clk_slow_i;
    r_next.cfg_en  = cfg_ok(r_next.dst, bus_state_i);
    // Detection only in D0 and D1; D2 and D3hot never look
    r_next.det_en  = (r_next.dst == PWR_D0) | (r_next.dst == PWR_D1);
    r_next.pme_n   = ~(r_next.pme_sts & r_next.wake_en);
    r_next.irq     = |(r_next.ists & r_next.ien);
  end

  ////////////////////////////////////////////////////////////////////
  // State register; rst_i is also the D3cold power-on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= ST_RST;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign wb_dat_o     = r_reg.rdat;
  assign wb_ack_o     = r_reg.ack;
  assign chip_reset_o = r_reg.chip_rst;
  assign xcvr_reset_o = r_reg.xrst;
  assign xcvr_ctrl_o  = r_reg.xctl;
  assign pwr_state_o  = r_reg.dst;
  assign net_en_o     = r_reg.net_en;
  assign func_en_o    = r_reg.func_en;
  assign cfg_en_o     = r_reg.cfg_en;
  assign pme_n_o      = r_reg.pme_n;
  assign irq_o        = r_reg.irq;
endmodule // pwr_wake_reset_ctrl

// ### include/pwr_pkg.sv
// Shared constants for the power, wake and reset control block.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus.
package pwr_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned HW_RST_MIN_US  = 100;
  localparam int unsigned HW_RST_MIN_CYC = HW_RST_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned NET_MIN_CLK_HZ = 16_000_000;

  // Register byte offsets
  localparam logic [7:0] MAIN_CTRL_OFS = 8'h00;
  localparam logic [7:0] XCVR_CTRL_OFS = 8'h04;
  localparam logic [7:0] WAKE_CFG_OFS  = 8'h08;
  localparam logic [7:0] PWR_STS_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_STS_OFS   = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS   = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS    = 8'h18;

  // Field positions
  localparam int unsigned SOFT_RST_BIT = 0;
  localparam int unsigned XCVR_RST_BIT = 15;
  localparam int unsigned WAKE_EN_BIT  = 18;
  localparam int unsigned PME_STS_BIT  = 15;
  localparam int unsigned DSTATE_LSB   = 0;
  localparam int unsigned BSTATE_LSB   = 2;

  // Interrupt event bits
  localparam int unsigned IRQ_N       = 3;
  localparam int unsigned EV_WAKE     = 0;
  localparam int unsigned EV_SRST     = 1;
  localparam int unsigned EV_XRST     = 2;

  // Reset values
  localparam logic [14:0] XCTL_RST = 15'h0000;
  localparam logic        WAKE_RST = 1'b0;

  // Wake pattern shape
  localparam int unsigned SYNC_FF_MIN = 6;
  localparam int unsigned ADDR_REPS   = 16;
  localparam logic [7:0]  SYNC_BYTE   = 8'hff;

  // Device power states (D3cold is power off, seen as rst_i)
  typedef enum logic [1:0] {
    PWR_D0    = 2'b00,
    PWR_D1    = 2'b01,
    PWR_D2    = 2'b10,
    PWR_D3HOT = 2'b11
  } pwr_dstate_e;

  // Bus power states
  typedef enum logic [1:0] {
    PWR_B0 = 2'b00,
    PWR_B1 = 2'b01,
    PWR_B2 = 2'b10,
    PWR_B3 = 2'b11
  } pwr_bstate_e;
endpackage

// ### design/pwr_wake_detect.sv
// Wake pattern frame detector: scans received bytes for the sync run
// and the repeated station address. Assumes one byte per valid cycle,
// sof and eof flags on first and last byte, filter and FCS at eof.
`timescale 1ns/1ps
module pwr_wake_detect import pwr_pkg::*; #(
  parameter int unsigned SYNC_MIN = SYNC_FF_MIN,
  parameter int unsigned REPS     = ADDR_REPS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        en_i,
  input  wire logic [47:0] station_addr_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_sof_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_addr_ok_i,
  input  wire logic        rx_fcs_ok_i,
  output logic             hit_o
);
  localparam int unsigned FW = $clog2(SYNC_MIN + 1);
  localparam int unsigned RW = $clog2(REPS);

  initial begin
    if (SYNC_MIN < 1 || REPS < 2) $error("pwr_wake_detect: bad pattern shape");
  end

  typedef struct packed {
    logic [FW-1:0] ff;
    logic          match;
    logic [2:0]    idx;
    logic [RW-1:0] rep;
    logic          found;
    logic          hit;
  } pwr_det_s;

  pwr_det_s r_reg, r_next;
  logic [7:0] abyte;

  ////////////////////////////////////////////////////////////////////
  // Byte scanner
  always_comb begin
    r_next = r_reg;
    r_next.hit = 1'b0;
    abyte = '0;
    if (rx_valid_i) begin
      if (rx_sof_i) begin
        r_next = '0;
      end
      // Address byte expected next, [47:40] first on the wire; taken
      // after the frame-start clear so no loop runs through r_next
      abyte = station_addr_i[8'(47 - 8 * r_next.idx) -: 8];
      if (r_next.match) begin
        if (rx_data_i == abyte) begin
          if (r_next.idx == 3'd5) begin
            r_next.idx = '0;
            if (r_next.rep == RW'(REPS - 1)) begin
              r_next.found = 1'b1;
              r_next.match = 1'b0;
              r_next.ff    = '0;
            end else begin
              r_next.rep = r_next.rep + 1'b1;
            end
          end else begin
            r_next.idx = r_next.idx + 3'd1;
          end
        end else begin
          // Broken copy: a sync byte here may start a fresh run
          r_next.match = 1'b0;
          r_next.idx   = '0;
          r_next.rep   = '0;
          r_next.ff    = (rx_data_i == SYNC_BYTE) ? FW'(1) : '0;
        end
      end else if (rx_data_i == SYNC_BYTE) begin
        if (r_next.ff != FW'(SYNC_MIN)) begin
          r_next.ff = r_next.ff + 1'b1;
        end
      end else if (r_next.ff == FW'(SYNC_MIN) &&
                   rx_data_i == station_addr_i[47:40]) begin
        r_next.match = 1'b1;
        r_next.idx   = 3'd1;
        r_next.rep   = '0;
      end else begin
        r_next.ff = '0;
      end
      // Scanning goes on after a find, so repeated patterns are fine
      if (rx_eof_i) begin
        r_next.hit = en_i & r_next.found & rx_addr_ok_i & rx_fcs_ok_i;
        r_next.ff    = '0;
        r_next.match = 1'b0;
        r_next.idx   = '0;
        r_next.rep   = '0;
        r_next.found = 1'b0;
      end
    end
    if (!en_i) begin
      r_next = '0;
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign hit_o = r_reg.hit;
endmodule // pwr_wake_detect

// ### tb/pwr_checker.sv
// Port-level checker for the power, wake and reset block.
// Assumes it is bound to pwr_wake_reset_ctrl; one clock domain.
`timescale 1ns/1ps
module pwr_checker import pwr_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic [1:0]        bus_state_i,
  input wire logic              bus_clk_slow_i,
  input wire logic              rx_valid_i,
  input wire logic              rx_eof_i,
  input wire logic              rx_addr_ok_i,
  input wire logic              rx_fcs_ok_i,
  input wire logic              chip_reset_o,
  input wire logic              xcvr_reset_o,
  input wire logic [14:0]       xcvr_ctrl_o,
  input wire logic [1:0]        pwr_state_o,
  input wire logic              net_en_o,
  input wire logic              func_en_o,
  input wire logic              cfg_en_o,
  input wire logic              pme_n_o
);
  logic [3:0] act_hist;
  logic       wr_req;
  logic       good_eof;
  // Software can move pme legally, so recent bus or reset activity masks it
  always_ff @(posedge clk_i) act_hist <= {act_hist[2:0], wb_cyc_i | chip_reset_o};
  assign wr_req   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & func_en_o;
  assign good_eof = rx_valid_i & rx_eof_i & rx_addr_ok_i & rx_fcs_ok_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  ////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_soft_reset: assert property (
    wr_req && wb_adr_i == MAIN_CTRL_OFS && wb_sel_i[0] && wb_dat_i[0] |-> ##[1:3] chip_reset_o)
    else $error("soft reset pulse missing");
  a_xcvr_reset: assert property (
    wr_req && wb_adr_i == XCVR_CTRL_OFS && wb_sel_i[1] && wb_dat_i[15]
    |-> ##[1:3] xcvr_reset_o ##1 xcvr_ctrl_o == 15'h0000)
    else $error("transceiver reset missing");
  a_pme_cause: assert property (
    $fell(pme_n_o) && act_hist == 4'h0 |-> $past(good_eof, 2))
    else $error("pme without good frame");
  a_pme_hold: assert property (
    !pme_n_o && act_hist == 4'h0 && !wb_cyc_i && !chip_reset_o |=> !pme_n_o)
    else $error("pme released by itself");
  a_net_off: assert property (
    (pwr_state_o != PWR_D0 || bus_clk_slow_i) [*2] |-> !net_en_o)
    else $error("network enabled when not allowed");
  a_func_off: assert property ((pwr_state_o != PWR_D0) [*2] |-> !func_en_o)
    else $error("function access outside D0");
  a_cfg_bus: assert property ((pwr_state_o[1] && bus_state_i[1]) [*2] |-> !cfg_en_o)
    else $error("config access in B2 or B3");
  c_wake: cover property ($fell(pme_n_o));
  c_chip: cover property (chip_reset_o);
  c_cfg: cover property (!cfg_en_o);
endmodule // pwr_checker

bind pwr_wake_reset_ctrl pwr_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .bus_state_i(bus_state_i), .bus_clk_slow_i(bus_clk_slow_i),
  .rx_valid_i(rx_valid_i), .rx_eof_i(rx_eof_i), .rx_addr_ok_i(rx_addr_ok_i),
  .rx_fcs_ok_i(rx_fcs_ok_i), .chip_reset_o(chip_reset_o), .xcvr_reset_o(xcvr_reset_o),
  .xcvr_ctrl_o(xcvr_ctrl_o), .pwr_state_o(pwr_state_o), .net_en_o(net_en_o),
  .func_en_o(func_en_o), .cfg_en_o(cfg_en_o), .pme_n_o(pme_n_o));

// ### tb/pwr_rx_model.sv
// Receive-path model: streams filtered frames one byte a clock.
// Assumes the block samples the byte stream at the rising edge.
`timescale 1ns/1ps
module pwr_rx_model (
  input  wire logic        clk_i,
  input  wire logic [47:0] addr_i,
  output logic             valid_o,
  output logic [7:0]       data_o,
  output logic             sof_o,
  output logic             eof_o,
  output logic             aok_o,
  output logic             fok_o
);
  initial begin
    {valid_o, data_o, sof_o, eof_o, aok_o, fok_o} = 13'h0000;
  end
  // One byte per edge, no back-pressure
  task automatic put(input logic [7:0] b, input logic s, input logic e);
    @(posedge clk_i);
    {valid_o, data_o, sof_o, eof_o} <= {1'b1, b, s, e};
  endtask
  // Sync run and address copies, repeated pats times in one payload
  task automatic send(input int nff, input int reps, input int pats,
                      input logic a_ok, input logic f_ok);
    int i;
    put(8'h00, 1'b1, 1'b0);
    repeat (pats) begin
      repeat (nff) put(8'hff, 1'b0, 1'b0);
      repeat (reps) for (i = 5; i >= 0; i--) put(addr_i[i*8 +: 8], 1'b0, 1'b0);
    end
    put(8'h5a, 1'b0, 1'b1);
    {aok_o, fok_o} <= {a_ok, f_ok};
    @(posedge clk_i);
    // Idle lines flip so a stale byte never looks like data
    {valid_o, sof_o, eof_o, aok_o, fok_o} <= {3'b000, ~a_ok, ~f_ok};
    data_o <= ~data_o;
  endtask
endmodule // pwr_rx_model

// ### tb/testbench.sv
// Self-checking bench for pwr_wake_reset_ctrl.
// Assumes a classic Wishbone slave acking one cycle after the request.
`timescale 1ns/1ps
module testbench import pwr_pkg::*; ();
  localparam logic [47:0] STA = 48'h02a1_b2c3_d4e5;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, slow = 1'b0;
  logic        ce = 1'b1, eep = 1'b1;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, rd, wb_dat_o;
  logic [1:0]  bst = 2'b00, pwr_state_o;
  logic [14:0] xcvr_ctrl_o;
  logic        wb_ack_o, chip_reset_o, xcvr_reset_o, net_en_o, func_en_o, cfg_en_o;
  logic        pme_n_o, irq_o, rx_v, rx_s, rx_e, rx_a, rx_f;
  logic [7:0]  rx_d;
  int          mismatches = 0, compares = 0, crst = 0, xrst = 0, n0, n1;

  pwr_wake_reset_ctrl #(.ADDR_W(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eeprom_wake_en_i(eep),
    .bus_state_i(bst), .bus_clk_slow_i(slow), .station_addr_i(STA), .rx_valid_i(rx_v),
    .rx_data_i(rx_d), .rx_sof_i(rx_s), .rx_eof_i(rx_e), .rx_addr_ok_i(rx_a),
    .rx_fcs_ok_i(rx_f), .chip_reset_o(chip_reset_o), .xcvr_reset_o(xcvr_reset_o),
    .xcvr_ctrl_o(xcvr_ctrl_o), .pwr_state_o(pwr_state_o), .net_en_o(net_en_o),
    .func_en_o(func_en_o), .cfg_en_o(cfg_en_o), .pme_n_o(pme_n_o), .irq_o(irq_o));
  pwr_rx_model rx (.clk_i(clk_i), .addr_i(STA), .valid_o(rx_v), .data_o(rx_d),
    .sof_o(rx_s), .eof_o(rx_e), .aok_o(rx_a), .fok_o(rx_f));

  always #10 clk_i = ~clk_i;
  // Pulse counters, sampled before the edge's own updates land
  always @(posedge clk_i) begin
    crst += int'(chip_reset_o === 1'b1);
    xrst += int'(xcvr_reset_o === 1'b1);
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle; waits for ack however long, the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'b00;
    // Registered ack: seen at the second edge after the request rises
    chk(32'(n), 32'h2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic do_reset(input int n);
    rst_i <= 1'b1;
    wait_clk(n);
    rst_i <= 1'b0;
    wait_clk(2);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset(input logic [31:0] wk);
    chk(32'({pme_n_o, irq_o, pwr_state_o, net_en_o}), 32'h11);
    rd_chk(WAKE_CFG_OFS, wk);
    rd_chk(PWR_STS_OFS, 32'h0);
    rd_chk(8'h40, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_wake;
    int i;
    int nf[4] = '{6, 6, 5, 6};
    int nr[4] = '{16, 16, 16, 15};
    logic ao[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic fo[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    for (i = 0; i < 4; i++) begin
      rx.send(nf[i], nr[i], 1, ao[i], fo[i]);
      wait_clk(4);
      chk(32'(pme_n_o), 32'h1);
    end
    rd_chk(IRQ_STS_OFS, 32'h0);
    rx.send(8, 16, 2, 1'b1, 1'b1);
    wait_clk(4);
    chk(32'(pme_n_o), 32'h0);
    rd_chk(PWR_STS_OFS, 32'h0000_8000);
    wr(IRQ_EN_OFS, 32'h1);
    wait_clk(2);
    chk(32'(irq_o), 32'h1);
    wr(IRQ_EN_OFS, 32'h0);
    wait_clk(2);
    chk(32'(irq_o), 32'h0);
    wr(IRQ_CLR_OFS, 32'h7);
    rd_chk(IRQ_STS_OFS, 32'h0);
    chk(32'(pme_n_o), 32'h0);
    wr(PWR_STS_OFS, 32'h0000_8000);
    wait_clk(2);
    chk(32'(pme_n_o), 32'h1);
    wr(WAKE_CFG_OFS, 32'h0);
    rx.send(6, 16, 1, 1'b1, 1'b1);
    wait_clk(4);
    chk(32'(pme_n_o), 32'h1);
    rd_chk(IRQ_STS_OFS, 32'h1);
    wr(IRQ_CLR_OFS, 32'h1);
    wr(WAKE_CFG_OFS, 32'h0004_0000);
    $display("wake test done");
  endtask
  task automatic t_soft;
    wr(XCVR_CTRL_OFS, 32'h0000_1234);
    wait_clk(2);
    chk(32'(xcvr_ctrl_o), 32'h1234);
    n0 = crst;
    wr(MAIN_CTRL_OFS, 32'h1);
    wait_clk(4);
    chk(32'(crst - n0), 32'h1);
    chk(32'(xcvr_ctrl_o), 32'h0);
    rd_chk(MAIN_CTRL_OFS, 32'h0);
    rd_chk(WAKE_CFG_OFS, 32'h0004_0000);
    rd_chk(IRQ_STS_OFS, 32'h2);
    $display("soft reset test done");
  endtask
  task automatic t_xcvr;
    wr(XCVR_CTRL_OFS, 32'h0000_0abc);
    n0 = crst;
    n1 = xrst;
    wr(XCVR_CTRL_OFS, 32'h0000_8abc);
    wait_clk(4);
    chk(32'(xrst - n1), 32'h1);
    chk(32'(crst - n0), 32'h0);
    chk(32'(xcvr_ctrl_o), 32'h0);
    rd_chk(XCVR_CTRL_OFS, 32'h0);
    rd_chk(IRQ_STS_OFS, 32'h6);
    $display("transceiver reset test done");
  endtask
  task automatic t_power;
    wr(PWR_STS_OFS, 32'h1);
    wait_clk(2);
    chk(32'({pwr_state_o, net_en_o, func_en_o}), 32'h4);
    rd_chk(WAKE_CFG_OFS, 32'h0);
    wr(WAKE_CFG_OFS, 32'h0);
    rx.send(6, 16, 1, 1'b1, 1'b1);
    wait_clk(4);
    chk(32'(pme_n_o), 32'h0);
    wr(PWR_STS_OFS, 32'h0000_8002);
    rx.send(6, 16, 1, 1'b1, 1'b1);
    wait_clk(4);
    chk(32'(pme_n_o), 32'h1);
    bst <= PWR_B2;
    wait_clk(3);
    chk(32'(cfg_en_o), 32'h0);
    rd_chk(PWR_STS_OFS, 32'h0);
    bst <= PWR_B1;
    wait_clk(3);
    rd_chk(PWR_STS_OFS, 32'h6);
    wr(PWR_STS_OFS, 32'h3);
    n0 = crst;
    wr(PWR_STS_OFS, 32'h0);
    wait_clk(4);
    chk(32'(crst - n0), 32'h1);
    chk(32'({pwr_state_o, func_en_o}), 32'h1);
    wr(WAKE_CFG_OFS, 32'h0004_0000);
    bst <= PWR_B0;
    $display("power state test done");
  endtask
  task automatic t_slow;
    // Clock enable low freezes the state, so net_en_o must not follow
    ce <= 1'b0;
    slow <= 1'b1;
    wait_clk(3);
    chk(32'(net_en_o), 32'h1);
    slow <= 1'b0;
    ce <= 1'b1;
    wait_clk(2);
    slow <= 1'b1;
    wait_clk(3);
    chk(32'(net_en_o), 32'h0);
    slow <= 1'b0;
    wait_clk(3);
    chk(32'(net_en_o), 32'h1);
    $display("slow clock test done");
  endtask
  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    do_reset(12);
    t_reset(32'h0004_0000);
    t_wake();
    t_soft();
    t_xcvr();
    t_power();
    t_slow();
    // Strap now low, and the full host reset length this time
    eep <= 1'b0;
    do_reset(HW_RST_MIN_CYC);
    t_reset(32'h0);
    finish_test();
  end
  // About 6100 cycles expected; cut off well beyond
  initial begin
    wait_clk(20000);
    mismatches++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  end
endmodule // testbench
